// >>> src/flash_cmd_status.sv
`timescale 1ns/100ps

// Behaviour
// - Bit 0 busy while operation runs
// - Bit 1 write latch; zero refuses program/erase
// - Latch clears after disable, program, erases, top
// - Bits 2,3 protection level, writable, reset 1
// - Level selects protected address region
// - Status write changes level if pin high/unlocked
// - Chip erase only when level is 00
// - Lock bit freezes level and lock when pin low
// - Bit 6 shows auto-increment mode, reset 0
// - Bits 4,5 read zero, no function
// - Eight-bit cycles, MSB first, rising-edge sampling
// - Select fall starts new instruction
// - Select rise mid-byte abandons instruction
// - Read 03h, fast read 0Bh; output idle inputs
// - Erase opcodes 20h, 52h/D8h, 60h/C7h
// - Program 02h and auto-program AFh
// - Status fetch 05h, unlock 50h, store 01h
// - Arm 06h, disarm 04h clears latch
// - Identification read 90h/ABh, continuous output
// - Store works only right after unlock
// - Address bit 0 picks maker or part code
// - Status fetch repeats until select rises
module flash_cmd_status #(
  parameter logic [7:0] MAKER_CODE = 8'hA5,  // Arbitrary value
  parameter logic [7:0] PART_CODE  = 8'h3C   // Arbitrary value
) (
  input  wire logic                   CLK,        // System clock
  input  wire logic                   RST,        // Synchronous reset, high
  input  wire logic                   SCK,        // Serial clock from host
  input  wire logic                   CE_N,       // Select, active low
  input  wire logic                   SI,         // Serial data in
  input  wire logic                   WP_N,       // Write guard pin, active low
  output logic                        SO_OUT,     // Serial data out value
  output logic                        SO_OE,      // Serial out drive enable
  output logic [15:0]                 ARRAY_ADDR, // Read address to array
  input  wire logic [7:0]             ARRAY_DATA, // Read data from array
  output logic                        OP_START,   // Program/erase start pulse
  output flash_cmd_pkg::op_req_t      OP_REQ,     // Program/erase request
  input  wire logic                   OP_DONE,    // Array operation finished
  output logic [7:0]                  STATE_WORD  // Live status word
);
  import flash_cmd_pkg::*;

  // Opcodes this block decodes
  function automatic logic known_op(input logic [7:0] op);
    case (op)
      OPC_READ, OPC_FAST_READ, OPC_SECTOR_ERASE, OPC_BLOCK_ERASE, OPC_BLOCK_ERASE2,
      OPC_CHIP_ERASE, OPC_CHIP_ERASE2, OPC_BYTE_PROG, OPC_AUTO_PROG, OPC_FETCH_STATE,
      OPC_UNLOCK_STATE, OPC_STORE_STATE, OPC_ARM_WRITE, OPC_DISARM_WRITE,
      OPC_READ_ID, OPC_READ_ID2: known_op = 1'b1;
      default: known_op = 1'b0;
    endcase
  endfunction

  // Byte index at which the output phase begins
  function automatic logic [2:0] out_start(input logic [7:0] op);
    case (op)
      OPC_READ:                  out_start = OUT_READ;
      OPC_FAST_READ:             out_start = OUT_FAST;
      OPC_FETCH_STATE:           out_start = OUT_STATE;
      OPC_READ_ID, OPC_READ_ID2: out_start = OUT_ID;
      default:                   out_start = OUT_NONE;
    endcase
  endfunction

  // Region guarded by the protection level
  function automatic logic is_protected(input logic [1:0] lvl, input logic [15:0] a);
    case (lvl)
      LVL_NONE:    is_protected = 1'b0;
      LVL_QUARTER: is_protected = (a[15:14] == QUARTER_TOP);
      LVL_HALF:    is_protected = a[15];
      default:     is_protected = 1'b1;
    endcase
  endfunction

  // ---- Serial clock domain ----
  logic       fresh;
  logic [2:0] bit_cnt;
  logic [2:0] byte_cnt;
  logic [7:0] shift;
  logic [7:0] opcode;
  logic       cmd_ok;
  logic [23:0] addr;
  logic [7:0] last_byte;
  logic [7:0] state_meta;
  logic [7:0] state_sync;
  logic [7:0] state_pipe;
  logic [7:0] state_last;
  logic [7:0] tx;
  logic [2:0] cur_bit;
  logic [2:0] cur_bytes;
  logic [7:0] in_byte;
  logic       byte_done;
  logic [2:0] start_at;
  logic       out_phase;
  logic       is_read;
  logic [7:0] src;
  logic       no_bits;

  // Select high arms a fresh start; the first edge of the next frame clears it
  always_ff @(posedge SCK or posedge CE_N) begin
    if (CE_N) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  // Captured at select rise: a frame without a single clock edge still
  // holds the previous frame's counters, which must not be replayed
  always_ff @(posedge CE_N) begin
    no_bits <= fresh;
  end

  // Counters restart on the first edge of a frame, not at select rise,
  // so the system side can still read the finished frame afterwards
  assign cur_bit   = fresh ? BIT_FIRST : bit_cnt;
  assign cur_bytes = fresh ? 3'h0 : byte_cnt;
  assign in_byte   = {shift[6:0], SI};
  assign byte_done = (cur_bit == BIT_LAST);
  assign start_at  = out_start(opcode);
  assign out_phase = cmd_ok && (start_at != OUT_NONE) && (byte_cnt >= start_at);
  assign is_read   = (opcode == OPC_READ) || (opcode == OPC_FAST_READ);
  assign ARRAY_ADDR = addr[15:0];

  // Input shifter and cycle counters, sampled on rising edges
  always_ff @(posedge SCK) begin
    if (!CE_N) begin
      shift   <= in_byte;
      bit_cnt <= cur_bit + 3'h1;
      if (byte_done && cur_bytes != CNT_MAX) begin
        byte_cnt <= cur_bytes + 3'h1;
      end else begin
        byte_cnt <= cur_bytes;
      end
      if (byte_done) begin
        last_byte <= in_byte;
      end
    end
  end

  // Opcode decode; busy refuses all but the status fetch
  always_ff @(posedge SCK) begin
    if (!CE_N && byte_done && cur_bytes == 3'h0) begin
      opcode <= in_byte;
      cmd_ok <= known_op(in_byte) &&
                (!state_sync[BUSY_BIT] || in_byte == OPC_FETCH_STATE);
    end
  end

  // Address bytes, then auto-increment during array reads
  always_ff @(posedge SCK) begin
    if (!CE_N) begin
      if (byte_done && cur_bytes >= ADDR_BYTE_FIRST && cur_bytes <= ADDR_BYTE_LAST) begin
        addr <= {addr[15:0], in_byte};
      end else if (out_phase && is_read && cur_bit == BIT_MID) begin
        addr <= addr + 24'h000001;
      end
    end
  end

  // Status word into this domain; a word is taken only once two synced
  // samples agree, so bits that change together never arrive torn
  always_ff @(posedge SCK) begin
    state_meta <= STATE_WORD;
    state_pipe <= state_meta;
    state_last <= state_pipe;
    if (state_pipe == state_last) begin
      state_sync <= state_last;
    end
  end

  // Source of each output byte, reloaded at every byte boundary
  always_comb begin
    case (opcode)
      OPC_FETCH_STATE:           src = state_sync;
      OPC_READ_ID, OPC_READ_ID2: src = addr[0] ? PART_CODE : MAKER_CODE;
      default:                   src = ARRAY_DATA;
    endcase
  end

  // Output shifts on falling edges; off during all input cycles
  always_ff @(negedge SCK or posedge CE_N) begin
    if (CE_N) begin
      SO_OE  <= 1'b0;
      SO_OUT <= 1'b0;
      tx     <= 8'h00;
    end else begin
      SO_OE <= !fresh && out_phase;
      if (bit_cnt == BIT_FIRST) begin
        tx     <= src;
        SO_OUT <= src[7];
      end else begin
        SO_OUT <= tx[BIT_LAST - bit_cnt];
      end
    end
  end

  // ---- System clock domain ----
  logic       ce_meta;
  logic       ce_sync;
  logic       ce_last;
  logic       wp_meta;
  logic       wp_sync;
  logic       busy;
  logic       write_latch_flag;
  logic [1:0] lvl;
  logic       auto_mode;
  logic       lock;
  logic       armed;
  logic [15:0] auto_ptr;
  logic       frame_end;
  logic       go;
  logic [15:0] tgt;
  logic       do_arm;
  logic       do_disarm;
  logic       do_unlock;
  logic       do_store;
  logic       do_byte;
  logic       do_auto_first;
  logic       do_auto_next;
  logic       do_sector;
  logic       do_block;
  logic       do_chip;
  logic       do_prog;
  logic       start;
  logic       auto_top;
  logic       can_store;

  // Two-flop synchronisers for select and write guard
  always_ff @(posedge CLK) begin
    if (RST) begin
      ce_meta <= 1'b1;
      ce_sync <= 1'b1;
      ce_last <= 1'b1;
      wp_meta <= 1'b1;
      wp_sync <= 1'b1;
    end else begin
      ce_meta <= CE_N;
      ce_sync <= ce_meta;
      ce_last <= ce_sync;
      wp_meta <= WP_N;
      wp_sync <= wp_meta;
    end
  end

  // Serial-side frame registers are quiet once select is high, so they
  // are read directly when the synchronised rise is seen
  assign frame_end = ce_sync && !ce_last;
  assign go  = frame_end && (bit_cnt == BIT_FIRST) && cmd_ok && !busy
               && !no_bits;
  assign tgt = addr[15:0];

  // Decode of the finished frame; length must match exactly
  assign do_arm    = go && opcode == OPC_ARM_WRITE && byte_cnt == LEN_SINGLE;
  assign do_disarm = go && opcode == OPC_DISARM_WRITE && byte_cnt == LEN_SINGLE;
  assign do_unlock = go && opcode == OPC_UNLOCK_STATE && byte_cnt == LEN_SINGLE;
  assign do_store  = go && opcode == OPC_STORE_STATE && byte_cnt == LEN_ONE_ARG
                     && armed;
  assign do_byte   = go && opcode == OPC_BYTE_PROG && byte_cnt == LEN_PROG
                     && write_latch_flag && !auto_mode && !is_protected(lvl, tgt);
  assign do_auto_first = go && opcode == OPC_AUTO_PROG && byte_cnt == LEN_PROG
                     && write_latch_flag && !auto_mode && !is_protected(lvl, tgt);
  assign do_auto_next  = go && opcode == OPC_AUTO_PROG && byte_cnt == LEN_ONE_ARG
                     && write_latch_flag && auto_mode && !is_protected(lvl, auto_ptr);
  assign do_sector = go && opcode == OPC_SECTOR_ERASE && byte_cnt == LEN_ADDR
                     && write_latch_flag && !is_protected(lvl, tgt);
  assign do_block  = go && (opcode == OPC_BLOCK_ERASE || opcode == OPC_BLOCK_ERASE2)
                     && byte_cnt == LEN_ADDR && write_latch_flag && !is_protected(lvl, tgt);
  assign do_chip   = go && (opcode == OPC_CHIP_ERASE || opcode == OPC_CHIP_ERASE2)
                     && byte_cnt == LEN_SINGLE && write_latch_flag && lvl == LVL_NONE;
  assign do_prog   = do_byte || do_auto_first || do_auto_next;
  assign start     = do_prog || do_sector || do_block || do_chip;
  assign auto_top  = (do_auto_first && tgt == TOP_ADDR) ||
                     (do_auto_next && auto_ptr == TOP_ADDR);
  assign can_store = wp_sync || !lock;

  // Request register towards the array sequencer
  always_ff @(posedge CLK) begin
    if (RST) begin
      OP_START <= 1'b0;
      OP_REQ   <= '{kind: OP_PROGRAM, addr: 16'h0000, data: 8'h00};
    end else begin
      OP_START <= start;
      if (do_prog) begin
        OP_REQ <= '{kind: OP_PROGRAM, addr: do_auto_next ? auto_ptr : tgt, data: last_byte};
      end else if (do_sector) begin
        OP_REQ <= '{kind: OP_SECTOR, addr: tgt, data: 8'h00};
      end else if (do_block) begin
        OP_REQ <= '{kind: OP_BLOCK, addr: tgt, data: 8'h00};
      end else if (do_chip) begin
        OP_REQ <= '{kind: OP_CHIP, addr: 16'h0000, data: 8'h00};
      end
    end
  end

  // Busy: a new start wins over a completion in the same cycle
  always_ff @(posedge CLK) begin
    if (RST) begin
      busy <= 1'b0;
    end else if (start) begin
      busy <= 1'b1;
    end else if (OP_DONE) begin
      busy <= 1'b0;
    end
  end

  // Write latch; cleared by disarm, byte program, erases and auto-program at the top
  always_ff @(posedge CLK) begin
    if (RST) begin
      write_latch_flag <= 1'b0;
    end else if (do_disarm || do_byte || do_sector || do_block || do_chip || auto_top) begin
      write_latch_flag <= 1'b0;
    end else if (do_arm) begin
      write_latch_flag <= 1'b1;
    end
  end

  // Auto-increment mode and its address pointer; no wrap at the top
  always_ff @(posedge CLK) begin
    if (RST) begin
      auto_mode <= 1'b0;
      auto_ptr  <= 16'h0000;
    end else if (do_disarm || auto_top) begin
      auto_mode <= 1'b0;
    end else if (do_auto_first) begin
      auto_mode <= 1'b1;
      auto_ptr  <= tgt + ADDR_STEP;
    end else if (do_auto_next) begin
      auto_ptr  <= auto_ptr + ADDR_STEP;
    end
  end

  // Status write window opens only for the frame right after unlock
  always_ff @(posedge CLK) begin
    if (RST) begin
      armed <= 1'b0;
    end else if (frame_end) begin
      armed <= do_unlock;
    end
  end

  // Protection level and lock; frozen while guard pin low and locked
  always_ff @(posedge CLK) begin
    if (RST) begin
      lvl  <= LVL_RESET;
      lock <= LOCK_RESET;
    end else if (do_store && can_store) begin
      lvl  <= {last_byte[LVL_HI_BIT], last_byte[LVL_LO_BIT]};
      lock <= last_byte[LOCK_BIT];
    end
  end

  // Assembled status word; reserved bits always zero
  always_comb begin
    STATE_WORD             = 8'h00;
    STATE_WORD[BUSY_BIT]   = busy;
    STATE_WORD[WEL_BIT]    = write_latch_flag;
    STATE_WORD[LVL_LO_BIT] = lvl[0];
    STATE_WORD[LVL_HI_BIT] = lvl[1];
    STATE_WORD[AUTO_BIT]   = auto_mode;
    STATE_WORD[LOCK_BIT]   = lock;
  end

endmodule

// >>> src/flash_cmd_pkg.sv
package flash_cmd_pkg;

  // Opcodes
  localparam logic [7:0] OPC_READ         = 8'h03;
  localparam logic [7:0] OPC_FAST_READ    = 8'h0B;
  localparam logic [7:0] OPC_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OPC_BLOCK_ERASE  = 8'h52;
  localparam logic [7:0] OPC_BLOCK_ERASE2 = 8'hD8;
  localparam logic [7:0] OPC_CHIP_ERASE   = 8'h60;
  localparam logic [7:0] OPC_CHIP_ERASE2  = 8'hC7;
  localparam logic [7:0] OPC_BYTE_PROG    = 8'h02;
  localparam logic [7:0] OPC_AUTO_PROG    = 8'hAF;
  localparam logic [7:0] OPC_FETCH_STATE  = 8'h05;
  localparam logic [7:0] OPC_UNLOCK_STATE = 8'h50;
  localparam logic [7:0] OPC_STORE_STATE  = 8'h01;
  localparam logic [7:0] OPC_ARM_WRITE    = 8'h06;
  localparam logic [7:0] OPC_DISARM_WRITE = 8'h04;
  localparam logic [7:0] OPC_READ_ID      = 8'h90;
  localparam logic [7:0] OPC_READ_ID2     = 8'hAB;

  // State word bit positions
  localparam int BUSY_BIT   = 0;
  localparam int WEL_BIT    = 1;
  localparam int LVL_LO_BIT = 2;
  localparam int LVL_HI_BIT = 3;
  localparam int AUTO_BIT   = 6;
  localparam int LOCK_BIT   = 7;

  // Power-up values
  localparam logic [1:0] LVL_RESET  = 2'b11;
  localparam logic       LOCK_RESET = 1'b0;

  // Bit and byte counting
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_MID   = 3'h3;
  localparam logic [2:0] BIT_LAST  = 3'h7;
  localparam logic [2:0] CNT_MAX   = 3'h7;
  localparam logic [2:0] ADDR_BYTE_FIRST = 3'h1;
  localparam logic [2:0] ADDR_BYTE_LAST  = 3'h3;

  // Whole-frame lengths in bytes
  localparam logic [2:0] LEN_SINGLE  = 3'h1;
  localparam logic [2:0] LEN_ONE_ARG = 3'h2;
  localparam logic [2:0] LEN_ADDR    = 3'h4;
  localparam logic [2:0] LEN_PROG    = 3'h5;

  // Byte index at which output starts; zero means never
  localparam logic [2:0] OUT_NONE  = 3'h0;
  localparam logic [2:0] OUT_STATE = 3'h1;
  localparam logic [2:0] OUT_READ  = 3'h4;
  localparam logic [2:0] OUT_FAST  = 3'h5;
  localparam logic [2:0] OUT_ID    = 3'h4;

  // Protection levels and array geometry
  localparam logic [1:0]  LVL_NONE    = 2'b00;
  localparam logic [1:0]  LVL_QUARTER = 2'b01;
  localparam logic [1:0]  LVL_HALF    = 2'b10;
  localparam logic [1:0]  QUARTER_TOP = 2'b11;
  localparam logic [15:0] TOP_ADDR    = 16'hFFFF;
  localparam logic [15:0] ADDR_STEP   = 16'h0001;

  typedef enum logic [1:0] {OP_PROGRAM, OP_SECTOR, OP_BLOCK, OP_CHIP} op_kind_t;

  // Request handed to the array sequencer
  typedef struct packed {
    op_kind_t    kind;
    logic [15:0] addr;
    logic [7:0]  data;
  } op_req_t;

endpackage

// >>> dv/flash_cmd_status_props.sv
`timescale 1ns/100ps

// System-side checks on the status word and array requests
module flash_cmd_status_props
  import flash_cmd_pkg::*;
(
  input wire logic       CLK,        // System clock
  input wire logic       RST,        // Synchronous reset
  input wire logic       CE_N,       // Select, active low
  input wire logic       SO_OE,      // Serial out enable
  input wire logic       OP_START,   // Accept pulse
  input wire op_req_t    OP_REQ,     // Accepted request
  input wire logic       OP_DONE,    // Array finished
  input wire logic [7:0] STATE_WORD  // Live status
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  // Reserved bits carry nothing
  rsv_zero_a: assert property (STATE_WORD[5:4] == 2'b00)
    else $error("reserved status bits set");
  // Reset must win over any pending array start
  pwr_up_a: assert property (disable iff (1'b0) RST |=> STATE_WORD == 8'h0C)
    else $error("status word wrong after reset");
  start_busy_a: assert property (OP_START |-> STATE_WORD[0])
    else $error("busy not set with accept");
  start_pulse_a: assert property (OP_START |=> !OP_START)
    else $error("accept pulse longer than one cycle");
  start_latch_a: assert property (OP_START |-> $past(STATE_WORD[1]))
    else $error("accept without write latch");
  chip_level_a: assert property (OP_START && OP_REQ.kind == OP_CHIP |->
    STATE_WORD[3:2] == LVL_NONE) else $error("chip erase under protection");
  prot_gate_a: assert property (OP_START && OP_REQ.kind != OP_CHIP |->
    STATE_WORD[3:2] == LVL_NONE
    || (STATE_WORD[3:2] == LVL_QUARTER && OP_REQ.addr[15:14] != 2'b11)
    || (STATE_WORD[3:2] == LVL_HALF && !OP_REQ.addr[15]))
    else $error("protected address accepted");
  done_clear_a: assert property (OP_DONE && !OP_START |=> !STATE_WORD[0])
    else $error("busy not cleared by done");
  busy_hold_a: assert property (STATE_WORD[0] && !OP_DONE |=> STATE_WORD[0])
    else $error("busy dropped early");
  so_idle_a: assert property ($past(CE_N) && CE_N |-> !SO_OE)
    else $error("serial out driven while deselected");
endmodule

bind flash_cmd_status flash_cmd_status_props flash_cmd_status_props_i (
  .CLK(CLK), .RST(RST), .CE_N(CE_N), .SO_OE(SO_OE), .OP_START(OP_START),
  .OP_REQ(OP_REQ), .OP_DONE(OP_DONE), .STATE_WORD(STATE_WORD));

// >>> dv/spi_host_model.sv
`timescale 1ns/100ps

// Mode 0 host; serial clock runs only inside frames
module spi_host_model (
  output logic      SCK,     // Serial clock
  output logic      CE_N,    // Select, active low
  output logic      SI,      // Host data out
  input  wire logic SO_OUT,  // Device data
  input  wire logic SO_OE    // Device drive enable
);
  logic [63:0] rx;  // Wire bits seen, one per rise
  wire  so_line = SO_OE ? SO_OUT : 1'bz;  // No pull on the line
  // Serial side has no reset; a definite select rise puts it idle
  initial begin
    SCK = 1'b0;
    CE_N = 1'b0;
    SI = 1'b1;
    #1 CE_N = 1'b1;
  end
  // Select pulse with no clock edge at all
  task automatic empty_frame;
    #100;
    CE_N = 1'b0;
    #100 CE_N = 1'b1;
  endtask
  // Gap first so the system side has taken the last frame
  task automatic xfer(input logic [63:0] tx, input int nbits);
    rx = '0;
    #100;
    CE_N = 1'b0;
    #5;
    for (int i = nbits - 1; i >= 0; i--) begin
      SI = tx[i];
      #3 SCK = 1'b1;
      rx = {rx[62:0], so_line};
      #3 SCK = 1'b0;
    end
    #3 CE_N = 1'b1;
    SI = ~SI;  // Released line must not look held
  endtask
endmodule

// >>> dv/spi_flash_command_status_logic_tb.sv
`timescale 1ns/100ps

module spi_flash_command_status_logic_tb;
  import flash_cmd_pkg::*;
  localparam logic [7:0] MAKER = 8'h5E;  // Arbitrary value
  localparam logic [7:0] PART  = 8'h81;  // Arbitrary value
  logic CLK, RST, WP_N, OP_DONE, SCK, CE_N, SI, SO_OUT, SO_OE, OP_START;
  logic [15:0] ARRAY_ADDR;
  logic [7:0]  ARRAY_DATA, STATE_WORD;
  op_req_t     OP_REQ;
  int          miscompares = 0, checks_done = 0, cycles = 0;

  flash_cmd_status #(.MAKER_CODE(MAKER), .PART_CODE(PART)) flash_cmd_status_i (
    .CLK(CLK), .RST(RST), .SCK(SCK), .CE_N(CE_N), .SI(SI), .WP_N(WP_N),
    .SO_OUT(SO_OUT), .SO_OE(SO_OE), .ARRAY_ADDR(ARRAY_ADDR), .ARRAY_DATA(ARRAY_DATA),
    .OP_START(OP_START), .OP_REQ(OP_REQ), .OP_DONE(OP_DONE), .STATE_WORD(STATE_WORD));
  spi_host_model spi_host_model_i (
    .SCK(SCK), .CE_N(CE_N), .SI(SI), .SO_OUT(SO_OUT), .SO_OE(SO_OE));

  // Array content depends on both address bytes
  assign ARRAY_DATA = ARRAY_ADDR[7:0] ^ ARRAY_ADDR[15:8];
  initial CLK = 1'b0;
  always #10 CLK = ~CLK;
  // Hang guard, far above the roughly 900 cycles used
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      final_report;
    end
  end

  task final_report;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic fr(input logic [63:0] tx, input int nb);
    spi_host_model_i.xfer(tx, nb * 8);
  endtask
  // Frame, then let the status update land
  task automatic fs(input logic [63:0] tx, input int nb, input logic [7:0] exp);
    fr(tx, nb);
    repeat (8) @(negedge CLK);
    chk(STATE_WORD, exp);
  endtask
  task automatic op_chk(input logic go, input op_kind_t k, input logic [15:0] a);
    logic seen;
    seen = 1'b0;
    repeat (10) begin
      @(negedge CLK);
      if (OP_START === 1'b1) begin
        seen = 1'b1;
        chk({OP_REQ.kind, OP_REQ.addr}, {k, a});
      end
    end
    chk(seen, go);
  endtask
  task automatic op_end;
    OP_DONE = 1'b1;
    @(negedge CLK);
    OP_DONE = 1'b0;
    repeat (2) @(negedge CLK);
    chk(STATE_WORD[0], 1'b0);
  endtask

  task automatic t_reset;
    chk(STATE_WORD, 8'h0C);
    fr({8'h05, 16'h0}, 3);
    chk(spi_host_model_i.rx[15:0], 16'h0C0C);
    chk(spi_host_model_i.rx[23:16], 8'hzz);
    $display("reset test done");
  endtask
  task automatic t_latch;
    spi_host_model_i.xfer(64'h03, 7);
    repeat (8) @(negedge CLK);
    chk(STATE_WORD[1], 1'b0);
    fs(64'h06, 1, 8'h0E);
    fs(64'h04, 1, 8'h0C);
    fs({8'h01, 8'h00}, 2, 8'h0C);
    fs(64'h50, 1, 8'h0C);
    spi_host_model_i.empty_frame;
    fs({8'h01, 8'h04}, 2, 8'h0C);
    fs(64'h50, 1, 8'h0C);
    fs({8'h01, 8'h04}, 2, 8'h04);
    $display("latch test done");
  endtask
  task automatic t_prot;
    fr({8'h02, 24'h000010, 8'h55}, 5);
    op_chk(1'b0, OP_PROGRAM, 16'h0);
    fs(64'h06, 1, 8'h06);
    fr({8'h20, 24'h00C000}, 4);
    op_chk(1'b0, OP_SECTOR, 16'h0);
    fr(64'h60, 1);
    op_chk(1'b0, OP_CHIP, 16'h0);
    fr({8'h20, 24'h001000}, 4);
    op_chk(1'b1, OP_SECTOR, 16'h1000);
    chk(STATE_WORD[1:0], 2'b01);
    op_end;
    $display("protect test done");
  endtask
  task automatic t_prog;
    logic [7:0] opc [4] = '{8'h52, 8'hD8, 8'h60, 8'hC7};
    op_kind_t   kd [4] = '{OP_BLOCK, OP_BLOCK, OP_CHIP, OP_CHIP};
    fs(64'h50, 1, 8'h04);
    fs({8'h01, 8'h00}, 2, 8'h00);
    fs(64'h06, 1, 8'h02);
    fr({8'h02, 24'h000010, 8'hA5}, 5);
    op_chk(1'b1, OP_PROGRAM, 16'h0010);
    chk(OP_REQ.data, 8'hA5);
    chk(STATE_WORD[1:0], 2'b01);
    fs(64'h06, 1, 8'h01);
    op_end;
    for (int i = 0; i < 4; i++) begin
      fs(64'h06, 1, 8'h02);
      fr(i < 2 ? {32'h0, opc[i], 24'h008000} : {56'h0, opc[i]}, i < 2 ? 4 : 1);
      op_chk(1'b1, kd[i], i < 2 ? 16'h8000 : 16'h0);
      op_end;
    end
    fs(64'h06, 1, 8'h02);
    fr({8'hAF, 24'h000020, 8'h11}, 5);
    op_chk(1'b1, OP_PROGRAM, 16'h0020);
    chk(STATE_WORD[6], 1'b1);
    op_end;
    fr({8'hAF, 8'h22}, 2);
    op_chk(1'b1, OP_PROGRAM, 16'h0021);
    chk(OP_REQ.data, 8'h22);
    op_end;
    fs(64'h04, 1, 8'h00);
    fs(64'h06, 1, 8'h02);
    fr({8'hAF, 24'h00FFFF, 8'h33}, 5);
    op_chk(1'b1, OP_PROGRAM, 16'hFFFF);
    chk(STATE_WORD, 8'h01);
    op_end;
    $display("program test done");
  endtask
  task automatic t_read;
    logic [7:0] idop [2] = '{8'h90, 8'hAB};
    fr({8'h03, 24'h001234, 16'h0}, 6);
    chk(spi_host_model_i.rx[15:0], 16'h2627);
    chk(spi_host_model_i.rx[47:40], 8'hzz);
    fr({8'h0B, 24'h001234, 24'h0}, 7);
    chk(spi_host_model_i.rx[15:0], 16'h2627);
    chk(spi_host_model_i.rx[23:16], 8'hzz);
    for (int i = 0; i < 4; i++) begin
      fr({idop[i % 2], 16'h0, 7'h0, i[1], 16'h0}, 6);
      chk(spi_host_model_i.rx[15:0], i[1] ? {PART, PART} : {MAKER, MAKER});
    end
    fr({8'hFF, 8'h00}, 2);
    chk(spi_host_model_i.rx[15:0], 16'hzzzz);
    $display("read test done");
  endtask
  task automatic t_lock;
    @(negedge CLK);
    WP_N = 1'b0;
    fs(64'h50, 1, 8'h00);
    fs({8'h01, 8'h8C}, 2, 8'h8C);
    fs(64'h50, 1, 8'h8C);
    fs({8'h01, 8'h00}, 2, 8'h8C);
    @(negedge CLK);
    WP_N = 1'b1;
    fs(64'h50, 1, 8'h8C);
    fs({8'h01, 8'h00}, 2, 8'h00);
    $display("lock test done");
  endtask

  initial begin
    RST = 1'b1;
    WP_N = 1'b1;
    OP_DONE = 1'b0;
    repeat (10) @(negedge CLK);
    RST = 1'b0;
    repeat (3) @(negedge CLK);
    t_reset;
    t_latch;
    t_prot;
    t_prog;
    t_read;
    t_lock;
    final_report;
  end
endmodule
